// [rtl/tx_channel_irq_status_mask.v]
// Purpose: Transmit-channel interrupt raw and masked status with set/clear enables.
// Assumes: Plain register port; read data appears the cycle after the read strobe.
// Notes: Pending flags are raised elsewhere; this block synchronises, shows and gates them.
`include "tx_irq_defines.vh"

// Summary of operation
// - Raw status register shows eight channel pending flags, bit n is channel n.
// - Masked status register shows pending flags gated by their enable bits.
// - Status bits 31 to 8 read zero and ignore writes.
// - Writing one to enable-set bit n enables channel n pending interrupt.
// - Writing one to enable-set bit 16+n enables channel n pulse interrupt.
// - Enable-set reserved bits 31-24 and 15-8 read zero.
// - Enable-clear register, same layout, writing one disables that enable bit.
module tx_channel_irq_status_mask #(
  parameter CHANNELS = 8
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire nrst_in,
  // Register port
  input wire [`TX_IRQ_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  // Channel events and interrupt lines
  input wire [CHANNELS-1:0] xmit_pending_in,
  input wire [CHANNELS-1:0] xmit_pulse_in,
  output wire pending_irq_out,
  output wire pulse_irq_out
);
  wire [CHANNELS-1:0] xmit_pending;
  wire [CHANNELS-1:0] xmit_pulse;
  wire [CHANNELS-1:0] xmit_pending_enable;
  wire [CHANNELS-1:0] xmit_pulse_enable;
  wire [CHANNELS-1:0] masked_status;
  wire set_sel;
  wire clr_sel;
  reg [31:0] rdata_d;

  // Both event sources cross in from channel logic that may run elsewhere.
  tx_irq_pending_sync #(.WIDTH(CHANNELS)) u_pend_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(xmit_pending_in),
    .sync_out(xmit_pending)
  );

  tx_irq_pending_sync #(.WIDTH(CHANNELS)) u_pulse_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(xmit_pulse_in),
    .sync_out(xmit_pulse)
  );

  assign set_sel = wr_in && (addr_in == `TX_IRQ_ENABLE_SET_OFS);
  assign clr_sel = wr_in && (addr_in == `TX_IRQ_ENABLE_CLEAR_OFS);

  tx_irq_enable_bits #(.WIDTH(CHANNELS)) u_pend_en (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .set_bits_in(set_sel ? wdata_in[`TX_IRQ_PEND_LSB +: CHANNELS] : {CHANNELS{1'b0}}),
    .clear_bits_in(clr_sel ? wdata_in[`TX_IRQ_PEND_LSB +: CHANNELS] : {CHANNELS{1'b0}}),
    .enable_q_out(xmit_pending_enable)
  );

  tx_irq_enable_bits #(.WIDTH(CHANNELS)) u_pulse_en (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .set_bits_in(set_sel ? wdata_in[`TX_IRQ_PULSE_LSB +: CHANNELS] : {CHANNELS{1'b0}}),
    .clear_bits_in(clr_sel ? wdata_in[`TX_IRQ_PULSE_LSB +: CHANNELS] : {CHANNELS{1'b0}}),
    .enable_q_out(xmit_pulse_enable)
  );

  assign masked_status = xmit_pending & xmit_pending_enable;

  // The level interrupt follows the masked view; the pulse line is gated the same way.
  assign pending_irq_out = |masked_status;
  assign pulse_irq_out = |(xmit_pulse & xmit_pulse_enable);

  always @* begin
    rdata_d = 32'h00000000;
    case (addr_in)
      `TX_IRQ_RAW_STATUS_OFS: begin
        rdata_d[CHANNELS-1:0] = xmit_pending;
      end
      `TX_IRQ_MASKED_STATUS_OFS: begin
        rdata_d[CHANNELS-1:0] = masked_status;
      end
      `TX_IRQ_ENABLE_SET_OFS, `TX_IRQ_ENABLE_CLEAR_OFS: begin
        rdata_d[`TX_IRQ_PEND_LSB +: CHANNELS] = xmit_pending_enable;
        rdata_d[`TX_IRQ_PULSE_LSB +: CHANNELS] = xmit_pulse_enable;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data stands for exactly one cycle after the strobe, zero otherwise.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      rdata_out <= rdata_d;
    end else begin
      rdata_out <= 32'h00000000;
    end
  end
endmodule // tx_channel_irq_status_mask

// [rtl/tx_irq_defines.vh]
// Purpose: Register map and field layout of the transmit interrupt status and enable block.
// Assumes: Byte-addressed plain register port, 8 transmit channels.
// Notes: Offsets are byte addresses of aligned 32-bit words.
`ifndef TX_IRQ_DEFINES_VH
`define TX_IRQ_DEFINES_VH

`define TX_IRQ_ADDR_W 8
`define TX_IRQ_RAW_STATUS_OFS 8'h00
`define TX_IRQ_MASKED_STATUS_OFS 8'h04
`define TX_IRQ_ENABLE_SET_OFS 8'h08
`define TX_IRQ_ENABLE_CLEAR_OFS 8'h0c
`define TX_IRQ_PEND_LSB 0
`define TX_IRQ_PULSE_LSB 16
`define TX_IRQ_ENABLE_RESET 8'h00
`define TX_IRQ_STATUS_RESET 8'h00

`endif

// [rtl/tx_irq_enable_bits.v]
// Purpose: One group of set-only and clear-only enable bits.
// Assumes: Set and clear strobes come from the register decoder on the same clock.
// Notes: A bit set and cleared in the same cycle ends set.
`include "tx_irq_defines.vh"

module tx_irq_enable_bits #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire nrst_in,
  // Set and clear requests
  input wire [WIDTH-1:0] set_bits_in,
  input wire [WIDTH-1:0] clear_bits_in,
  // Stored enables
  output reg [WIDTH-1:0] enable_q_out
);
  wire [WIDTH-1:0] enable_d;

  assign enable_d = (enable_q_out & ~clear_bits_in) | set_bits_in;

  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      enable_q_out <= {WIDTH{1'b0}};
    end else begin
      enable_q_out <= enable_d;
    end
  end
endmodule // tx_irq_enable_bits

// [rtl/tx_irq_pending_sync.v]
// Purpose: Two-stage synchroniser for the per-channel pending flags.
// Assumes: Pending flags are levels from outside this clock domain.
// Notes: Only the second stage is read by other logic.
module tx_irq_pending_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire nrst_in,
  // Flags
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // tx_irq_pending_sync

// [verif/test_tx_channel_irq_status_mask.sv]
// Purpose: Self-checking bench for the transmit interrupt status block.
// Assumes: Fixed stimulus on one 20 MHz clock.
// Notes: Flags are held two edges so they cross the synchroniser.
module test_tx_channel_irq_status_mask;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, pirq, qirq;
  logic [7:0] addr_in = 8'h00, pnd = 8'h00, pls = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  int fail_count = 0, checks = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  tx_channel_irq_status_mask DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .xmit_pending_in(pnd),
    .xmit_pulse_in(pls), .pending_irq_out(pirq), .pulse_irq_out(qirq));
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Every bus task drives at a rising edge and judges read data at the falling edge where it stands.
  task wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [7:0] ra, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    addr_in <= ra;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(rdata_out, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(rdata_out, e);
  endtask
  task settle;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask
  task reset_values;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
  endtask
  task set_and_mask;
    @(posedge clk_sys_in);
    pnd <= 8'ha5;
    settle();
    rd(8'h00, 32'h000000a5);
    rd(8'h04, 32'h0);
    chk(pirq, 32'h0);
    wr_rd(8'h08, 32'hffffffff, 8'h08, 32'h00ff00ff);
    rd(8'h04, 32'h000000a5);
    chk(pirq, 32'h1);
    wr_rd(8'h00, 32'hffffffff, 8'h00, 32'h000000a5);
    wr_rd(8'h08, 32'h0, 8'h08, 32'h00ff00ff);
  endtask
  task clear_and_pulse;
    wr_rd(8'h0c, 32'h00fe00fe, 8'h0c, 32'h00010001);
    rd(8'h04, 32'h00000001);
    @(posedge clk_sys_in);
    pls <= 8'h01;
    settle();
    chk(qirq, 32'h1);
    wr_rd(8'h0c, 32'hffffffff, 8'h08, 32'h0);
    chk({pirq, qirq}, 32'h0);
    rd(8'h10, 32'h0);
  endtask
  // A reset in mid-run must drop every enable while the channel flags stay up.
  task reset_midrun;
    wr_rd(8'h08, 32'h00030003, 8'h0c, 32'h00030003);
    chk({pirq, qirq}, 32'h3);
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(8'h08, 32'h0);
    chk({pirq, qirq}, 32'h0);
    rd(8'h00, 32'h000000a5);
  endtask
  task complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    reset_values();
    set_and_mask();
    clear_and_pulse();
    reset_midrun();
    complete_run();
  end
endmodule // test_tx_channel_irq_status_mask

// [verif/tx_irq_properties.sv]
// Purpose: Port checker for the transmit interrupt status block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Read-back checks need the read right after the write.
`include "tx_irq_defines.vh"
module tx_irq_properties #(
  parameter CHANNELS = 8
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [`TX_IRQ_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire [CHANNELS-1:0] xmit_pending_in,
  input wire [CHANNELS-1:0] xmit_pulse_in,
  input wire pending_irq_out,
  input wire pulse_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  idle_rdata_zero_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  status_rsvd_zero_a: assert property (rd_in && addr_in < 8'h08 |=> rdata_out[31:8] == 24'h0)
    else $error("status upper bits not zero");
  enable_rsvd_zero_a: assert property (rd_in && addr_in[3] |=> {rdata_out[31:24], rdata_out[15:8]} == 16'h0)
    else $error("enable reserved bits not zero");
  raw_follows_a: assert property (rd_in && addr_in == 8'h00 && $stable(xmit_pending_in) &&
    xmit_pending_in == $past(xmit_pending_in, 2) |=> rdata_out[7:0] == $past(xmit_pending_in))
    else $error("raw status differs from held flags");
  masked_irq_a: assert property (rd_in && addr_in == 8'h04 |=> (|rdata_out[7:0]) == $past(pending_irq_out))
    else $error("masked status and interrupt disagree");
  set_pend_a: assert property (wr_in && addr_in == 8'h08 ##1 rd_in && addr_in[3] |=>
    (rdata_out[7:0] & $past(wdata_in[7:0], 2)) == $past(wdata_in[7:0], 2))
    else $error("pending enable not set");
  set_pulse_a: assert property (wr_in && addr_in == 8'h08 ##1 rd_in && addr_in[3] |=>
    (rdata_out[23:16] & $past(wdata_in[23:16], 2)) == $past(wdata_in[23:16], 2))
    else $error("pulse enable not set");
  clear_enable_a: assert property (wr_in && addr_in == 8'h0c ##1 rd_in && addr_in[3] |=>
    (rdata_out & $past(wdata_in, 2) & 32'h00ff00ff) == 32'h0)
    else $error("enable not cleared");
endmodule // tx_irq_properties
bind tx_channel_irq_status_mask tx_irq_properties #(.CHANNELS(CHANNELS)) chk (.*);
